// *** hw/core_cycle_and_sfr_file.v ***
// Instruction cycle timing and core special function register file
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
// What this block does
// [RULE_01] Clock divided into four phase enables
// [RULE_02] Program counter increments at phase one
// [RULE_03] Program word captured at phase four
// [RULE_04] Instruction register loads at phase one
// [RULE_05] Fetch overlaps execute, one per cycle
// [RULE_06] Branch flushes prefetched word, two cycles
// [RULE_07] Operand read phase two, write phase four
// [RULE_08] Address zero goes through indirect pointer
// [RULE_09] Status holds pages, timeout, powerdown, flags
// [RULE_10] Status reset values per reset cause
// [RULE_11] Counter low byte, directions reset ones
// [RULE_12] Timer config resets to all ones
// [RULE_13] Indirect pointer top bits set on reset
// [RULE_14] Data registers kept through warm reset
// [RULE_15] Port A four bits, rest read zero
// [RULE_16] Address two is counter low byte only
// [RULE_17] Address seven port C or general
// [RULE_18] Counter advances by one unless branching
// [RULE_19] Call or low-byte write clears bit eight
// [RULE_20] Direction and config loaded by instruction
`include "core_sfr_regs.vh"

module core_cycle_and_sfr_file #(
    parameter LARGE_VARIANT  = 1,
    parameter PORT_C_PRESENT = 1
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    input  wire        warm_reset,
    input  wire        warm_timeout_flag,
    input  wire        warm_power_down_flag,
    output reg  [10:0] prog_addr,
    input  wire [11:0] prog_data,
    output wire        q1,
    output wire        q2,
    output wire        q3,
    output wire        q4,
    output reg  [11:0] instr_reg,
    output reg         instr_valid,
    input  wire [4:0]  exec_file_addr,
    output reg  [7:0]  exec_rdata,
    input  wire        exec_file_we,
    input  wire [7:0]  exec_file_wdata,
    input  wire        exec_w_we,
    input  wire [7:0]  exec_w_data,
    output reg  [7:0]  working_reg,
    input  wire [2:0]  exec_flag_we,
    input  wire [2:0]  exec_flags,
    input  wire        exec_jump,
    input  wire        exec_call,
    input  wire [8:0]  exec_target,
    input  wire        exec_dir_we,
    input  wire [1:0]  exec_dir_sel,
    input  wire        exec_option_we,
    output reg  [7:0]  core_status,
    output reg  [7:0]  timer_count,
    output reg  [7:0]  indirect_pointer,
    output reg  [7:0]  port_a_data,
    output reg  [7:0]  port_b_data,
    output wire [7:0]  port_c_data,
    output reg  [7:0]  port_a_direction,
    output reg  [7:0]  port_b_direction,
    output reg  [7:0]  port_c_direction,
    output reg  [5:0]  timer_prescale_config
);

    localparam [7:0]  FSR_TOP = LARGE_VARIANT ? `FSR_TOP_LARGE
                                              : `FSR_TOP_SMALL;
    localparam [10:0] PC_MASK = LARGE_VARIANT ? `RST_PC
                                              : `PC_MASK_SMALL;

    reg  [1:0]  phase;
    reg         run;
    reg  [10:0] program_counter;
    reg  [11:0] fetch_latch;
    reg         flush;
    reg  [7:0]  port_c_store;
    reg  [7:0]  gpr [`FA_GPR_LO:`FA_GPR_HI];
    reg         dp_wr;
    reg         dp_ok;
    reg  [5:0]  dp_idx;
    reg         rd_late;
    integer     i;

    wire        ap;
    wire        core_q4;
    wire        core_wr;
    wire        sw_wr;
    wire        wr_en;
    wire [4:0]  wr_addr;
    wire [7:0]  wr_data;
    wire        pcl_write;
    wire        pc_load;
    wire [1:0]  page;
    wire [10:0] next_pc;

    // ----------------------------------------------------------------
    // Helper decoders
    // ----------------------------------------------------------------
    // [RULE_08] indirect address resolve
    function [4:0] resolve;
        input [4:0] a;
        begin
            resolve = (a == `FA_INDIRECT) ? indirect_pointer[4:0] : a;
        end
    endfunction

    function [7:0] file_rd;
        input [4:0] a;
        begin
            case (a)
                // Pointer at zero reads as zero, never recursing
                `FA_INDIRECT: file_rd = 8'h00;
                `FA_TIMER:    file_rd = timer_count;
                // [RULE_16] low byte only
                `FA_PCL:      file_rd = program_counter[7:0];
                `FA_STATUS:   file_rd = core_status;
                `FA_FSR:      file_rd = indirect_pointer;
                // [RULE_15] upper nibble zero
                `FA_PORT_A_DATA:    file_rd = port_a_data & `PORT_A_DATA_MASK;
                `FA_PORT_B_DATA:    file_rd = port_b_data;
                // [RULE_17] address seven storage
                `FA_PORT_C_DATA:    file_rd = port_c_store;
                default:      file_rd = gpr[a];
            endcase
        end
    endfunction

    // [RULE_20] direction and config not in file map
    function [31:0] bus_rd;
        input       ok;
        input [5:0] idx;
        begin
            if (!ok) begin
                bus_rd = 32'h0;
            end else if (idx < `IDX_FILE_END) begin
                bus_rd = {24'h0, file_rd(resolve(idx[4:0]))};
            end else begin
                case (idx)
                    `IDX_CTRL:   bus_rd = {31'h0, run};
                    `IDX_VIEW:   bus_rd = {instr_reg, instr_valid,
                                           phase, 6'h0,
                                           program_counter};
                    `IDX_DIR_A:  bus_rd = {24'h0, port_a_direction};
                    `IDX_DIR_B:  bus_rd = {24'h0, port_b_direction};
                    `IDX_DIR_C:  bus_rd = {24'h0, port_c_direction};
                    `IDX_OPTION: bus_rd = {26'h0, timer_prescale_config};
                    default:     bus_rd = 32'h0;
                endcase
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // Phase generator
    // ----------------------------------------------------------------
    // [RULE_01] four phase enables
    assign q1 = run & (phase == `PH_Q1);
    assign q2 = run & (phase == `PH_Q2);
    assign q3 = run & (phase == `PH_Q3);
    assign q4 = run & (phase == `PH_Q4);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase <= `PH_Q1;
        end else if (warm_reset) begin
            phase <= `PH_Q1;
        end else if (run) begin
            phase <= phase + 2'h1;
        end
    end

    // ----------------------------------------------------------------
    // Shared write port
    // ----------------------------------------------------------------
    // Core write wins a collision; the bus write is then dropped
    assign core_q4   = q4 & instr_valid;
    // [RULE_07] destination write at phase four
    assign core_wr   = core_q4 & exec_file_we;
    assign sw_wr     = dp_wr & dp_ok & (dp_idx < `IDX_FILE_END);
    assign wr_en     = (core_wr | sw_wr) & ~warm_reset;
    assign wr_addr   = core_wr ? resolve(exec_file_addr)
                               : resolve(dp_idx[4:0]);
    assign wr_data   = core_wr ? exec_file_wdata : hwdata[7:0];
    assign pcl_write = wr_en & (wr_addr == `FA_PCL);

    // ----------------------------------------------------------------
    // Program counter and pipeline
    // ----------------------------------------------------------------
    assign page = LARGE_VARIANT ? core_status[`ST_PCPAGE] : 2'b00;
    // [RULE_19] page from status, bit eight cleared
    assign next_pc = (core_q4 & exec_jump)
                   ? {page, exec_target}
                   : {page, 1'b0,
                      (core_q4 & exec_call) ? exec_target[7:0]
                                            : wr_data};
    assign pc_load = (core_q4 & (exec_jump | exec_call)) | pcl_write;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // [RULE_11] counter to all ones
            program_counter <= `RST_PC & PC_MASK;
            prog_addr       <= 11'h0;
            fetch_latch     <= 12'h0;
            instr_reg       <= 12'h0;
            instr_valid     <= 1'b0;
            flush           <= 1'b1;
        end else if (warm_reset) begin
            program_counter <= `RST_PC & PC_MASK;
            instr_valid     <= 1'b0;
            flush           <= 1'b1;
        end else begin
            if (q1) begin
                // [RULE_02] advance and start fetch
                prog_addr <= program_counter;
                // [RULE_04] present captured word
                instr_reg <= fetch_latch;
                // [RULE_05] overlap, valid unless flushed
                instr_valid <= ~flush;
                flush       <= 1'b0;
            end
            if (q4) begin
                // [RULE_03] capture program word
                fetch_latch <= prog_data;
            end
            if (pc_load) begin
                // [RULE_06] discard prefetched word
                program_counter <= next_pc & PC_MASK;
                flush           <= 1'b1;
            end else if (q1) begin
                // [RULE_18] advance by one
                program_counter <= (program_counter + 11'h1) & PC_MASK;
            end
        end
    end

    // ----------------------------------------------------------------
    // Operand read
    // ----------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            exec_rdata <= 8'h0;
        end else if (q2) begin
            // [RULE_07] operand read at phase two
            exec_rdata <= file_rd(resolve(exec_file_addr));
        end
    end

    // ----------------------------------------------------------------
    // File registers
    // ----------------------------------------------------------------
    assign port_c_data = PORT_C_PRESENT ? port_c_store : 8'h0;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // [RULE_10] power-on status value
            core_status           <= `RST_STATUS_POR;
            // [RULE_13] top pointer bits set
            indirect_pointer      <= FSR_TOP;
            timer_count           <= 8'h0;
            working_reg           <= 8'h0;
            port_a_data           <= 8'h0;
            port_b_data           <= 8'h0;
            port_c_store          <= 8'h0;
            // [RULE_11] directions to all ones
            port_a_direction      <= `RST_ONES8;
            port_b_direction      <= `RST_ONES8;
            port_c_direction      <= `RST_ONES8;
            // [RULE_12] config to all ones
            timer_prescale_config <= `RST_OPTION;
            for (i = `FA_GPR_LO; i <= `FA_GPR_HI; i = i + 1) begin
                gpr[i] <= 8'h0;
            end
        end else if (warm_reset) begin
            // [RULE_10] pages clear, cause flags, flags kept
            core_status[`ST_PAGE] <= 3'b000;
            core_status[`ST_TO]   <= warm_timeout_flag;
            core_status[`ST_PD]   <= warm_power_down_flag;
            // [RULE_13] top bits set, others kept
            indirect_pointer      <= indirect_pointer | FSR_TOP;
            // [RULE_11] directions to all ones
            port_a_direction      <= `RST_ONES8;
            port_b_direction      <= `RST_ONES8;
            port_c_direction      <= `RST_ONES8;
            // [RULE_12] config to all ones
            timer_prescale_config <= `RST_OPTION;
            // [RULE_14] data registers untouched here
        end else begin
            if (wr_en) begin
                case (wr_addr)
                    `FA_INDIRECT, `FA_PCL: ;
                    `FA_TIMER:  timer_count <= wr_data;
                    `FA_STATUS: begin
                        // [RULE_09] cause flags are read-only
                        core_status[`ST_PAGE]  <= wr_data[`ST_PAGE];
                        core_status[`ST_FLAGS] <= wr_data[`ST_FLAGS];
                    end
                    `FA_FSR:    indirect_pointer <= wr_data;
                    // [RULE_15] only low nibble stored
                    `FA_PORT_A_DATA:  port_a_data <= wr_data & `PORT_A_DATA_MASK;
                    `FA_PORT_B_DATA:  port_b_data <= wr_data;
                    `FA_PORT_C_DATA:  port_c_store <= wr_data;
                    default:    gpr[wr_addr] <= wr_data;
                endcase
            end
            // Flag results override a same-cycle status write
            for (i = 0; i < 3; i = i + 1) begin
                if (core_q4 && exec_flag_we[i]) begin
                    core_status[i] <= exec_flags[i];
                end
            end
            if (core_q4 & exec_w_we) begin
                working_reg <= exec_w_data;
            end
            // [RULE_20] loaded from working register
            if (core_q4 & exec_dir_we) begin
                case (exec_dir_sel)
                    2'h1:    port_a_direction <= working_reg;
                    2'h2:    port_b_direction <= working_reg;
                    2'h3:    port_c_direction <= working_reg;
                    default: ;
                endcase
            end else if (dp_wr & dp_ok) begin
                case (dp_idx)
                    `IDX_DIR_A: port_a_direction <= hwdata[7:0];
                    `IDX_DIR_B: port_b_direction <= hwdata[7:0];
                    `IDX_DIR_C: port_c_direction <= hwdata[7:0];
                    default:    ;
                endcase
            end
            if (core_q4 & exec_option_we) begin
                timer_prescale_config <= working_reg[5:0];
            end else if (dp_wr & dp_ok & (dp_idx == `IDX_OPTION)) begin
                timer_prescale_config <= hwdata[5:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    // A read right behind a write waits one cycle so it sees the write
    assign ap        = hsel & htrans[1] & hready;
    assign hreadyout = ~rd_late;
    assign hresp     = 1'b0;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr   <= 1'b0;
            dp_ok   <= 1'b0;
            dp_idx  <= 6'h0;
            rd_late <= 1'b0;
            hrdata  <= 32'h0;
            run     <= 1'b1;
        end else begin
            if (hready) begin
                dp_wr   <= ap & hwrite;
                dp_ok   <= (haddr[31:8] == 24'h0) & (haddr[1:0] == 2'b00);
                dp_idx  <= haddr[7:2];
                rd_late <= ap & ~hwrite & dp_wr;
                if (ap & ~hwrite & ~dp_wr) begin
                    hrdata <= bus_rd((haddr[31:8] == 24'h0)
                                     & (haddr[1:0] == 2'b00),
                                     haddr[7:2]);
                end
            end else begin
                rd_late <= 1'b0;
                hrdata  <= bus_rd(dp_ok, dp_idx);
            end
            if (dp_wr & dp_ok & (dp_idx == `IDX_CTRL)) begin
                run <= hwdata[`CTRL_RUN];
            end
        end
    end

endmodule

// *** include/core_sfr_regs.vh ***
// Offsets, field positions and reset values of the core register file
`ifndef CORE_SFR_REGS_VH
`define CORE_SFR_REGS_VH

// ----------------------------------------------------------------
// File map addresses (also the bus word index)
// ----------------------------------------------------------------
`define FA_INDIRECT 5'h00
`define FA_TIMER    5'h01
`define FA_PCL      5'h02
`define FA_STATUS   5'h03
`define FA_FSR      5'h04
`define FA_PORT_A_DATA    5'h05
`define FA_PORT_B_DATA    5'h06
`define FA_PORT_C_DATA    5'h07
`define FA_GPR_LO   8
`define FA_GPR_HI   31

// ----------------------------------------------------------------
// Bus word indices beyond the file map
// ----------------------------------------------------------------
`define IDX_FILE_END 6'h20
`define IDX_CTRL     6'h20
`define IDX_VIEW     6'h21
`define IDX_DIR_A    6'h22
`define IDX_DIR_B    6'h23
`define IDX_DIR_C    6'h24
`define IDX_OPTION   6'h25
`define CTRL_RUN     0

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define ST_PAGE   7:5
`define ST_PCPAGE 6:5
`define ST_TO     4
`define ST_PD     3
`define ST_FLAGS  2:0

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define RST_ONES8      8'hff
`define RST_OPTION     6'h3f
`define RST_STATUS_POR 8'h18
`define RST_PC         11'h7ff
`define PC_MASK_SMALL  11'h1ff
`define FSR_TOP_LARGE  8'h80
`define FSR_TOP_SMALL  8'he0
`define PORT_A_DATA_MASK     8'h0f

// ----------------------------------------------------------------
// Phase codes
// ----------------------------------------------------------------
`define PH_Q1 2'h0
`define PH_Q2 2'h1
`define PH_Q3 2'h2
`define PH_Q4 2'h3

`endif

// *** verif/core_sfr_asserts.sv ***
// Concurrent checks on the core cycle and register file ports
`timescale 1ns/1ns
module core_sfr_asserts (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire        q1,
    input wire        q2,
    input wire        q3,
    input wire        q4,
    input wire        warm_reset,
    input wire        warm_timeout_flag,
    input wire        warm_power_down_flag,
    input wire [10:0] prog_addr,
    input wire [11:0] prog_data,
    input wire [11:0] instr_reg,
    input wire        instr_valid,
    input wire [7:0]  exec_rdata,
    input wire        exec_jump,
    input wire        exec_call,
    input wire [7:0]  core_status,
    input wire [7:0]  indirect_pointer,
    input wire [7:0]  port_b_data,
    input wire [7:0]  port_a_direction,
    input wire [5:0]  timer_prescale_config
);
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    wire br_now = q4 && instr_valid && (exec_jump || exec_call);
    reg  redirected;
    // Next fetch after a redirect is not a plus-one step
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            redirected <= 1'b1;
        end else if (br_now || warm_reset) begin
            redirected <= 1'b1;
        end else if (q1) begin
            redirected <= 1'b0;
        end
    end

    sequence s_phase_walk;
        q2 ##1 q3 ##1 q4 ##1 q1;
    endsequence
    sequence s_flushed;
        q1 ##1 !instr_valid;
    endsequence
    sequence s_kept;
        q1 ##1 instr_valid;
    endsequence

    a_phase_onehot: assert property ($onehot({q1, q2, q3, q4}))
        else $error("phase enables not one-hot");
    // Sampled guard: the cycle that sees warm reset starts no attempt
    a_phase_order: assert property (
        disable iff (!hresetn || warm_reset)
        q1 && !warm_reset |=> s_phase_walk)
        else $error("phase order broken");
    a_addr_at_q1: assert property (
        $changed(prog_addr) |-> $past(q1))
        else $error("fetch address moved outside phase one");
    a_addr_step: assert property (
        q1 && !redirected && !warm_reset |=>
        prog_addr == $past(prog_addr) + 11'h1)
        else $error("fetch address did not step by one");
    a_fetch_capture: assert property (
        disable iff (!hresetn || warm_reset)
        q4 && !warm_reset |-> ##2 instr_reg == $past(prog_data, 2))
        else $error("instruction word not captured");
    a_flush_slot: assert property (
        disable iff (!hresetn || warm_reset) br_now |=> s_flushed)
        else $error("slot after branch not flushed");
    a_kept_slot: assert property (
        disable iff (!hresetn || warm_reset)
        (!hsel[*3] ##1 (q4 && instr_valid && !exec_jump && !exec_call
        && !hsel)) |=> s_kept)
        else $error("slot dropped without branch");
    a_rdata_q2: assert property (
        $changed(exec_rdata) |-> $past(q2))
        else $error("operand changed outside phase two");
    a_por_values: assert property (
        $rose(hresetn) |-> core_status == 8'h18 &&
        indirect_pointer == 8'h80 && port_a_direction == 8'hff &&
        timer_prescale_config == 6'h3f)
        else $error("power-on values wrong");
    a_warm_status: assert property (warm_reset |=>
        core_status == {3'b000, $past(warm_timeout_flag),
        $past(warm_power_down_flag), $past(core_status[2:0])})
        else $error("status wrong after warm reset");
    a_warm_keep: assert property (warm_reset |=>
        port_a_direction == 8'hff && timer_prescale_config == 6'h3f &&
        indirect_pointer[7] && port_b_data == $past(port_b_data))
        else $error("warm reset values wrong");
endmodule

bind core_cycle_and_sfr_file core_sfr_asserts i_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .q1(q1), .q2(q2),
    .q3(q3), .q4(q4), .warm_reset(warm_reset),
    .warm_timeout_flag(warm_timeout_flag),
    .warm_power_down_flag(warm_power_down_flag), .prog_addr(prog_addr),
    .prog_data(prog_data), .instr_reg(instr_reg),
    .instr_valid(instr_valid), .exec_rdata(exec_rdata),
    .exec_jump(exec_jump), .exec_call(exec_call),
    .core_status(core_status), .indirect_pointer(indirect_pointer),
    .port_b_data(port_b_data), .port_a_direction(port_a_direction),
    .timer_prescale_config(timer_prescale_config)
);

// *** verif/test_core_cycle_and_sfr_file.sv ***
// Self-checking bench for the core cycle and register file
`timescale 1ns/1ns
module test_core_cycle_and_sfr_file;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic        warm_reset = 1'b0;
    logic        warm_power_down_flag = 1'b0;
    logic [11:0] prog_data = 12'h0;
    logic [5:0]  ctl = 6'h0;
    logic [8:0]  exec_target = 9'h0;
    logic [7:0]  exec_data = 8'h0;
    wire         hreadyout;
    wire         hresp;
    wire  [31:0] hrdata;
    wire  [10:0] prog_addr;
    wire  [11:0] instr_reg;
    wire         instr_valid;
    wire  [7:0]  exec_rdata;
    wire  [7:0]  working_reg;
    wire         q1, q2, q3, q4;
    logic [31:0] expq[$];
    int          err_count = 0;
    int          n_checks = 0;
    logic        rd_ph = 1'b0;
    logic [7:0]  r1, r2, r3, r4, r5;
    logic [8:0]  t;
    logic [7:0]  ta[7];
    logic [7:0]  te[7];

    core_cycle_and_sfr_file i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .warm_reset(warm_reset),
        .warm_timeout_flag(1'b0),
        .warm_power_down_flag(warm_power_down_flag),
        .prog_addr(prog_addr), .prog_data(prog_data), .q1(q1), .q2(q2),
        .q3(q3), .q4(q4), .instr_reg(instr_reg), .instr_valid(instr_valid),
        .exec_file_addr(5'h09), .exec_rdata(exec_rdata),
        .exec_file_we(ctl[2]), .exec_file_wdata(exec_data),
        .exec_w_we(ctl[3]), .exec_w_data(exec_data),
        .working_reg(working_reg), .exec_flag_we({3{ctl[2]}}),
        .exec_flags(exec_data[2:0]), .exec_jump(ctl[0]),
        .exec_call(ctl[1]), .exec_target(exec_target),
        .exec_dir_we(ctl[4]), .exec_dir_sel(2'h2),
        .exec_option_we(ctl[5]), .core_status(), .timer_count(),
        .indirect_pointer(), .port_a_data(), .port_b_data(),
        .port_c_data(), .port_a_direction(), .port_b_direction(),
        .port_c_direction(), .timer_prescale_config()
    );

    always #5 hclk = ~hclk;
    always @(posedge hclk) prog_data <= pmem(prog_addr);

    function logic [11:0] pmem(input logic [10:0] a);
        return {1'b0, a} ^ 12'h9c3;
    endfunction

    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask

    task end_of_test();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task hang();
        err_count++;
        $display("CHECK FAILED wait expected done seen timeout");
        end_of_test();
    endtask

    // -----------------------------------------------------------
    // Bus master, one transfer at a time
    // -----------------------------------------------------------
    task wait_rdy();
        int i;
        for (i = 0; i < 20; i++) begin
            @(negedge hclk);
            if (hreadyout === 1'b1) break;
        end
        if (i == 20) hang();
        @(posedge hclk);
    endtask

    task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= wr;
        wait_rdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wr ? d : 32'h0;
        if (!wr) expq.push_back(d);
        wait_rdy();
    endtask

    // Read data settles well before the closing edge
    always @(negedge hclk) begin
        if (rd_ph && hreadyout === 1'b1 && expq.size() > 0) begin
            chk("hrdata", hrdata, expq.pop_front());
            chk("hresp", hresp, 1'b0);
        end
        if (hreadyout === 1'b1) rd_ph = hsel && htrans[1] && !hwrite;
    end

    // -----------------------------------------------------------
    // Core side: act in the phase-four slot of a valid instruction
    // -----------------------------------------------------------
    task op(input logic [5:0] k, input logic [8:0] d);
        int i;
        for (i = 0; i < 40; i++) begin
            @(posedge hclk);
            #1;
            if (q3 === 1'b1 && instr_valid === 1'b1) break;
        end
        if (i == 40) hang();
        @(posedge hclk);
        ctl <= k;
        exec_data <= d[7:0];
        exec_target <= d;
        @(posedge hclk);
        ctl <= 6'h0;
    endtask

    task branch(input logic [5:0] k, input logic [10:0] e);
        op(k, t);
        @(posedge hclk);
        #1;
        chk("fetch_addr", prog_addr, e);
        chk("slot_valid", instr_valid, 1'b0);
        repeat (4) @(posedge hclk);
        #1;
        chk("fetch_addr", prog_addr, 11'(e + 11'h1));
        chk("slot_valid", instr_valid, 1'b1);
        chk("instr_reg", instr_reg, pmem(e));
    endtask

    initial begin
        r1 = 8'($urandom(90));
        r2 = 8'($urandom);
        r3 = 8'($urandom);
        r4 = 8'($urandom);
        r5 = 8'($urandom);
        t = 9'($urandom);
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        ta = '{8'h08, 8'h0c, 8'h10, 8'h88, 8'h8c, 8'h94, 8'h98};
        // Low byte has taken one phase-one step past all ones
        te = '{8'h00, 8'h18, 8'h80, 8'hff, 8'hff, 8'h3f, 8'h00};
        foreach (ta[i]) bus(1'b0, ta[i], te[i]);
        bus(1'b1, 12'h014, r1);
        bus(1'b0, 12'h014, r1 & 8'h0f);
        bus(1'b1, 12'h00c, 32'he5);
        bus(1'b0, 12'h00c, 32'hfd);
        bus(1'b1, 12'h010, 32'h0b);
        bus(1'b1, 12'h000, r2);
        bus(1'b0, 12'h02c, r2);
        bus(1'b0, 12'h000, r2);
        op(6'h04, {1'b0, r3});
        repeat (2) @(posedge hclk);
        #1;
        chk("exec_rdata", exec_rdata, r3);
        bus(1'b0, 12'h024, r3);
        bus(1'b0, 12'h00c, {5'h1f, r3[2:0]});
        op(6'h08, {1'b0, r4});
        op(6'h30, 9'h0);
        bus(1'b0, 12'h08c, r4);
        bus(1'b0, 12'h094, r4[5:0]);
        branch(6'h01, {2'h3, t});
        branch(6'h02, {2'h3, 1'b0, t[7:0]});
        bus(1'b1, 12'h018, r5);
        bus(1'b1, 12'h01c, r2);
        @(posedge hclk);
        warm_power_down_flag <= 1'b1;
        warm_reset <= 1'b1;
        @(posedge hclk);
        warm_reset <= 1'b0;
        ta = '{8'h08, 8'h0c, 8'h10, 8'h18, 8'h8c, 8'h94, 8'h24};
        te = '{8'h00, 8'h08 | r3[2:0], 8'h8b, r5, 8'hff, 8'h3f, r3};
        foreach (ta[i]) bus(1'b0, ta[i], te[i]);
        bus(1'b0, 12'h01c, r2);
        chk("working_reg", working_reg, r4);
        end_of_test();
    end
endmodule
